// ---- logic/sam_pkg.sv ----
// Purpose: shared constants and types of the serial converter control block
// Assumes: one system clock, all link pins arrive asynchronously
// Notes: address word is sent mode flag first, then channel msb first
package sam_pkg;
  // address word layout
  localparam int ADDR_BITS = 4;
  localparam int ADDR_MODE_POS = 3; // 1 = single-ended, 0 = differential
  localparam int CH_W = 3;
  // result word layout
  localparam int MAG_BITS = 10;
  localparam int RES_BITS = MAG_BITS + 1;
  localparam int RES_SIGN_POS = 10;
  // timing in serial clock periods
  localparam int ACQ_CLKS_DEF = 4;
  localparam int CONV_CLKS_DEF = 12;
  localparam int CNT_W = 5;
  // synchroniser pin positions
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_PD = 3;
  localparam int PIN_N = 4;
  // reset values
  localparam logic [PIN_N-1:0] PINS_RST = 4'h2; // chip select idles high
  localparam logic [CH_W-1:0] CH_RST = 3'h0;

  typedef struct packed {
    logic single_ended;
    logic [CH_W-1:0] channel;
  } sam_sel_t;

  typedef struct packed {
    logic sign;
    logic [MAG_BITS-1:0] mag;
  } sam_res_t;

  typedef struct packed {
    logic data;
    logic data_oe;
    logic status;
    logic status_oe;
  } sam_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACQ, ST_CONV, ST_SHIFT, ST_DONE
  } sam_state_t;
endpackage

// ---- logic/sam_ctrl.sv ----
// Purpose: digital control and serial exchange of a muxed sar converter
// Assumes: serial clock, chip select, address and power-down are pins,
//          sampled by clk; the analog core hands over a signed result
// Notes: serial clock must stay far below clk/6 to be seen reliably
`timescale 1ns/10ps

// What this block does
// - Shift address bit in on each of the first four serial clock rises while selected.
// - Loaded address drives the analog channel selection.
// - One to eight channels; address picks single-ended or differential.
// - Result leaves on falling edges, least significant bit first, sign last.
// - Acquisition, conversion and exchange are timed by the serial clock.
// - Chip select low enables functions; high disables them.
// - Data output driven once conversion is done and chip select low.
// - Power-down input high powers down; low resumes operation.
// - Status output floats while chip select is high.
// - Selected: status high during conversion, low otherwise.
// - Result is ten magnitude bits plus a sign bit.
module sam_ctrl #(
  parameter int NUM_CH = 8,
  parameter int ACQ_CLKS = sam_pkg::ACQ_CLKS_DEF,
  parameter int CONV_CLKS = sam_pkg::CONV_CLKS_DEF
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic sclk_pin, // serial clock from host
  input wire logic cs_n_pin, // chip select, active low
  input wire logic serial_addr_in, // serial address input
  input wire logic power_down_in, // power-down request, high = down
  input wire sam_pkg::sam_res_t conv_result, // result from analog core
  output sam_pkg::sam_sel_t analog_sel, // mux selection of analog_inputs
  output logic sample_hold, // high while input is being acquired
  output logic conv_active, // high while conversion runs
  output logic powered_down, // analog core power-down
  output sam_pkg::sam_pins_t out_pins // data and status with enables
);
  // last count of each phase; every counter runs from zero
  localparam logic [sam_pkg::CNT_W-1:0] ADDR_LAST =
    sam_pkg::CNT_W'(sam_pkg::ADDR_BITS - 1);
  localparam logic [sam_pkg::CNT_W-1:0] ACQ_LAST =
    sam_pkg::CNT_W'(ACQ_CLKS - 1);
  localparam logic [sam_pkg::CNT_W-1:0] CONV_LAST =
    sam_pkg::CNT_W'(CONV_CLKS - 1);
  localparam logic [sam_pkg::CNT_W-1:0] RES_LAST =
    sam_pkg::CNT_W'(sam_pkg::RES_BITS - 1);
  localparam logic [sam_pkg::CH_W-1:0] CH_MASK =
    sam_pkg::CH_W'(NUM_CH - 1);

  // limits the loaded channel to the channels this part really has
  function automatic sam_pkg::sam_sel_t decode_addr(
    input logic [sam_pkg::ADDR_BITS-1:0] a);
    sam_pkg::sam_sel_t s;
    s.single_ended = a[sam_pkg::ADDR_MODE_POS];
    s.channel = a[sam_pkg::CH_W-1:0] & CH_MASK;
    return s;
  endfunction

  // filtered pins; the agreement stage costs a clk but rejects glitches
  logic [sam_pkg::PIN_N-1:0] pins_raw;
  logic [sam_pkg::PIN_N-1:0] sync1_q, sync2_q, sync3_q;
  logic [sam_pkg::PIN_N-1:0] filt_q, filt_d;
  logic sclk_rise, sclk_fall, selected, pd;

  // sequencer state and datapath registers
  sam_pkg::sam_state_t state_q, state_d;
  logic [sam_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [sam_pkg::ADDR_BITS-1:0] addr_q, addr_d;
  sam_pkg::sam_sel_t sel_q, sel_d;
  logic [sam_pkg::RES_BITS-1:0] shift_q, shift_d;
  sam_pkg::sam_pins_t pins_q, pins_d;

  assign pins_raw = {power_down_in, serial_addr_in, cs_n_pin, sclk_pin};

  // three-stage sampling; a level counts once stages two and three agree
  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < sam_pkg::PIN_N; i++) begin
      if (sync2_q[i] == sync3_q[i]) begin
        filt_d[i] = sync3_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q <= sam_pkg::PINS_RST;
      sync2_q <= sam_pkg::PINS_RST;
      sync3_q <= sam_pkg::PINS_RST;
      filt_q <= sam_pkg::PINS_RST;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= filt_d;
    end
  end

  // edges of the filtered serial clock
  assign sclk_rise = filt_d[sam_pkg::PIN_SCLK] & ~filt_q[sam_pkg::PIN_SCLK];
  assign sclk_fall = ~filt_d[sam_pkg::PIN_SCLK] & filt_q[sam_pkg::PIN_SCLK];
  assign selected = ~filt_q[sam_pkg::PIN_CS_N];
  assign pd = filt_q[sam_pkg::PIN_PD];

  // sequencer: address, acquisition, conversion, result shift
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    sel_d = sel_q;
    shift_d = shift_q;
    if (pd) begin
      state_d = sam_pkg::ST_IDLE;
      cnt_d = '0;
    end else if (!selected) begin
      state_d = sam_pkg::ST_IDLE;
      cnt_d = '0;
      addr_d = '0;
    end else begin
      unique case (state_q)
        sam_pkg::ST_IDLE: begin
          state_d = sam_pkg::ST_ADDR;
          cnt_d = '0;
        end
        sam_pkg::ST_ADDR: begin
          if (sclk_rise) begin
            addr_d = {addr_q[sam_pkg::ADDR_BITS-2:0],
                      filt_q[sam_pkg::PIN_DIN]};
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == ADDR_LAST) begin
              sel_d = decode_addr(addr_d);
              state_d = sam_pkg::ST_ACQ;
              cnt_d = '0;
            end
          end
        end
        sam_pkg::ST_ACQ: begin
          if (sclk_fall) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == ACQ_LAST) begin
              state_d = sam_pkg::ST_CONV;
              cnt_d = '0;
            end
          end
        end
        sam_pkg::ST_CONV: begin
          if (sclk_fall) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CONV_LAST) begin
              shift_d = {conv_result.sign, conv_result.mag};
              state_d = sam_pkg::ST_SHIFT;
              cnt_d = '0;
            end
          end
        end
        sam_pkg::ST_SHIFT: begin
          if (sclk_fall) begin
            shift_d = {1'b0, shift_q[sam_pkg::RES_BITS-1:1]};
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == RES_LAST) begin
              state_d = sam_pkg::ST_DONE;
              cnt_d = '0;
            end
          end
        end
        sam_pkg::ST_DONE: begin
          // result fully sent; data stays driven low until deselect
          state_d = sam_pkg::ST_DONE; // new frame needs a new select
        end
      endcase
    end
  end

  // output pins; enables follow the sequencer state of the same cycle
  always_comb begin
    pins_d = '0;
    pins_d.data_oe = selected && !pd &&
      (state_d == sam_pkg::ST_SHIFT || state_d == sam_pkg::ST_DONE);
    pins_d.data = (state_d == sam_pkg::ST_SHIFT) ? shift_d[0] : 1'b0;
    pins_d.status_oe = selected;
    pins_d.status = selected && (state_d == sam_pkg::ST_CONV);
  end

  // state and registered outputs; reset leaves the block idle, floating
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= sam_pkg::ST_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      sel_q <= '{single_ended: 1'b1, channel: sam_pkg::CH_RST};
      shift_q <= '0;
      pins_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      sel_q <= sel_d;
      shift_q <= shift_d;
      pins_q <= pins_d;
    end
  end

  // analog core controls
  assign analog_sel = sel_q;
  assign sample_hold = (state_q == sam_pkg::ST_ACQ);
  assign conv_active = (state_q == sam_pkg::ST_CONV);
  assign powered_down = pd;
  assign out_pins = pins_q;
endmodule

// ---- test/sam_ctrl_chk.sv ----
// Purpose: port checks of the converter control block
// Assumes: pin filter settles within 8 clk
// Notes: bound from the bench top
`timescale 1ns/10ps
module sam_chk (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic cs_n_pin, // chip select
  input wire logic power_down_in, // power-down pin
  input wire logic sample_hold, // acquisition running
  input wire logic conv_active, // conversion running
  input wire logic powered_down, // filtered power-down
  input wire sam_pkg::sam_sel_t analog_sel, // mux select
  input wire sam_pkg::sam_pins_t out_pins // data and status
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // long enough deselected for the filter to have seen it
  sequence s_desel;
    cs_n_pin [*8];
  endsequence
  // long enough selected for the filter to have seen it
  sequence s_sel;
    !cs_n_pin [*8];
  endsequence
  // acquisition left while still selected and powered
  sequence s_acq_end;
    $fell(sample_hold) && out_pins.status_oe && !$past(powered_down);
  endsequence
  a_status_float: assert property (s_desel |-> !out_pins.status_oe)
    else $error("status driven while idle");
  a_status_drive: assert property (s_sel |-> out_pins.status_oe)
    else $error("status floating while selected");
  a_data_float: assert property (s_desel |-> !out_pins.data_oe)
    else $error("data driven while idle");
  a_sel_quiet: assert property (s_desel |-> $stable(analog_sel))
    else $error("select moved while idle");
  a_status_rise: assert property ($rose(conv_active) && !cs_n_pin |->
    ##[0:2] out_pins.status)
    else $error("status late");
  a_status_low: assert property (!conv_active [*3] |-> !out_pins.status)
    else $error("status high outside conversion");
  a_pd_on: assert property (power_down_in [*8] |-> powered_down)
    else $error("power-down ignored");
  a_pd_off: assert property (!power_down_in [*8] |-> !powered_down)
    else $error("power-down stuck");
  a_data_after: assert property ($rose(out_pins.data_oe) |->
    $past(conv_active) || $past(conv_active, 2))
    else $error("data before conversion end");
  a_acq_to_conv: assert property (s_acq_end |-> conv_active)
    else $error("acquisition did not lead to conversion");
endmodule

// ---- test/sam_host.sv ----
// Purpose: host serial master running one frame
// Assumes: half period of 17 clk, so the serial clock stays under 3 MHz
// Notes: serial clock rests low between frames
`timescale 1ns/10ps
module sam_host (
  input wire logic clk, // system clock
  input wire sam_pkg::sam_pins_t pins, // device outputs
  output logic sclk, // serial clock
  output logic cs_n, // chip select, active low
  output logic din // address bit
);
  localparam int HALF = 17; // clk per half period, about 2.9 MHz
  logic data_line;
  // released data line rests high on its pull-up
  assign data_line = pins.data_oe ? pins.data : 1'b1;
  initial begin
    sclk = 0;
    cs_n = 1;
    din = 0;
  end
  // selected frame, serial clock below its upper limit
  task automatic frame(input logic [3:0] a, input int n,
      output logic [10:0] r);
    r = '0;
    @(negedge clk) cs_n = 0;
    for (int i = 1; i <= n; i++) begin
      // address msb first, then a toggling unused line
      din = (i <= 4) ? a[4-i] : ~din;
      repeat (HALF) @(negedge clk);
      sclk = 1;
      repeat (HALF) @(negedge clk);
      if (i >= 20) r[i-20] = data_line;
      sclk = 0;
    end
    repeat (HALF) @(negedge clk);
    cs_n = 1;
    // deselect held long enough for the pin filter to see it
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// ---- test/tb_sam_ctrl.sv ----
// Purpose: self-checking bench of the converter control block
// Assumes: host model drives the serial pins
// Notes: all channel codes in both modes are exchanged
`timescale 1ns/10ps
module tb_sam_ctrl;
  logic clk = 0;
  logic srst = 1;
  logic power_down_in = 0;
  logic sclk, cs_n, din, conv_active, sample_hold, powered_down;
  sam_pkg::sam_res_t res_in = '0;
  sam_pkg::sam_sel_t analog_sel;
  sam_pkg::sam_pins_t out_pins;
  logic [10:0] got;
  int miscompares = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  sam_ctrl sam_ctrl_inst (.clk(clk), .srst(srst), .sclk_pin(sclk),
    .cs_n_pin(cs_n), .serial_addr_in(din), .power_down_in(power_down_in),
    .conv_result(res_in), .analog_sel(analog_sel),
    .sample_hold(sample_hold), .conv_active(conv_active),
    .powered_down(powered_down), .out_pins(out_pins));
  sam_host sam_host_inst (.clk(clk), .pins(out_pins), .sclk(sclk),
    .cs_n(cs_n), .din(din));
  task automatic check(input logic [10:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // full exchange; sign set on differential codes
  task automatic t_conv(input logic [3:0] a);
    res_in = {~a[3], 6'h2B, a};
    sam_host_inst.frame(a, 30, got);
    check(got, res_in);
    check({7'h0, analog_sel}, {7'h0, a});
    repeat (8) @(negedge clk);
    check({10'h0, out_pins.data_oe | out_pins.status_oe}, 11'h0);
  endtask
  // cut address must not leak into the next frame
  task automatic t_abort;
    sam_host_inst.frame(4'hA, 2, got);
    check({7'h0, analog_sel}, 11'h00F);
    check({9'h0, out_pins.data_oe, out_pins.status_oe}, 11'h0);
    t_conv(4'h5);
  endtask
  // no exchange while powered down; the line stays on its pull-up
  task automatic t_pd;
    power_down_in = 1;
    repeat (8) @(negedge clk);
    check({10'h0, powered_down}, 11'h001);
    sam_host_inst.frame(4'h9, 30, got);
    check(got, 11'h7FF);
    power_down_in = 0;
    repeat (8) @(negedge clk);
    check({10'h0, powered_down}, 11'h000);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    srst = 0;
    for (int a = 0; a < 16; a++)
      t_conv(4'(a));
    t_abort;
    t_pd;
    final_report;
  end
  // watchdog: the frames need about 200 us
  initial begin
    #400000;
    miscompares++;
    final_report;
  end
endmodule
bind sam_ctrl sam_chk sam_chk_inst (.clk(clk), .srst(srst),
  .cs_n_pin(cs_n_pin), .power_down_in(power_down_in),
  .sample_hold(sample_hold), .conv_active(conv_active),
  .powered_down(powered_down), .analog_sel(analog_sel),
  .out_pins(out_pins));
